/* src/vic_defines.svh */
// Constants of the vectored interrupt controller: offsets, fields, resets.
// Assumes a 32-bit APB address; registers sit at full byte addresses.
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// Register byte addresses
`define VIC_A_N_STA    32'hFFFF_0000
`define VIC_A_N_SIG    32'hFFFF_0004
`define VIC_A_N_EN     32'hFFFF_0008
`define VIC_A_N_CLR    32'hFFFF_000C
`define VIC_A_SWCFG    32'hFFFF_0010
`define VIC_A_BASE     32'hFFFF_0014
`define VIC_A_VEC      32'hFFFF_001C
`define VIC_A_PRI0     32'hFFFF_0020
`define VIC_A_PRI1     32'hFFFF_0024
`define VIC_A_PRI2     32'hFFFF_0028
`define VIC_A_NEST     32'hFFFF_0030
`define VIC_A_F_STA    32'hFFFF_0100
`define VIC_A_F_SIG    32'hFFFF_0104
`define VIC_A_F_EN     32'hFFFF_0108
`define VIC_A_F_CLR    32'hFFFF_010C

// Reset values
`define VIC_RST_32     32'h0000_0000
`define VIC_RST_16     16'h0000
`define VIC_RST_CTL    2'h0

// Source bits that exist: 1, 3..6, 10..19
`define VIC_SRC_MASK   32'h000F_FC7A
`define VIC_SRC_SW     1
`define VIC_SRC_LAST   19
`define VIC_SRC_W      5

// Software interrupt config fields
`define VIC_SW_NORM    1
`define VIC_SW_FAST    2

// Nesting control bits
`define VIC_NEST_NORM  0
`define VIC_NEST_FAST  1

// Vector readout layout
`define VIC_VEC_BASE_LO 7
`define VIC_VEC_SRC_LO  2
`define VIC_LVL_W       3
`define VIC_LVL_LOWEST  3'h7

`endif

/* src/vic_pkg.sv */
// Types of the vectored interrupt controller.
// Assumes vic_defines.svh is on the include path.
`include "vic_defines.svh"

package vic_pkg;

  // Whole register state of the controller
  typedef struct packed {
    logic [31:0] n_en;     // normal_enable_mask
    logic [31:0] f_en;     // fast_enable_mask
    logic        sw_n;     // programmed normal source
    logic        sw_f;     // programmed fast source
    logic [15:0] base;     // vector_table_base
    logic [31:0] pri0;     // priority_levels_first
    logic [31:0] pri1;     // priority_levels_second
    logic [31:0] pri2;     // priority_levels_third
    logic [1:0]  nest;     // nesting_control
    logic [31:0] rdata;    // APB read data
    logic        ready;    // APB ready
    logic        err;      // APB slave error
    logic        irq;      // normal request to core
    logic        fiq;      // fast request to core
  } vic_state_t;

endpackage

/* src/vic_top.sv */
// Vectored interrupt controller with APB register access.
// Assumes peripheral sources are levels on pclk; core samples irq/fiq.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "vic_defines.svh"

// Rules from the document
// RL1: Fast clear ones drop fast enables
// RL2: Fast status is source AND enable
// RL3: Any fast status bit raises fast request
// RL4: No vector unless vectored mode enabled
// RL5: Programmed interrupts bypass masks, update both
// RL6: Config bit 2 drives fast bit 1
// RL7: Config bit 1 drives normal bit 1
// RL8: Sources hold requests past minimum latency
// RL9: Control bit 0 enables normal vectoring
// RL10: Control bit 1 enables fast vectoring; here the bit is stored and read back but drives nothing
// RL11: Eight levels per path, fast outranks; here only the normal path is ranked by level
// RL12: Per-source routine via vector base table
// RL13: Base is 16 bits, upper reads zero
// RL14: Vector readout holds base and source
// RL15: Software reads vector only when servicing
// RL16: Priority levels 0..7, zero highest
// RL17: First priority register field layout
// RL18: Source 0 has no priority field
// RL19: Enabling one path disables other path
// RL20: OR of fast status forms bit 0
// RL21: Fast enable one unmasks fast source
// RL22: Equal levels pick lowest source index
module vic_top (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Peripheral sources, same clock
  input  wire logic [31:0] src_lines,
  // Requests to the core
  output logic             irq_req,
  output logic             fiq_req
);

  vic_pkg::vic_state_t s_q;
  vic_pkg::vic_state_t s_d;

  // Per-source priority levels
  logic [`VIC_LVL_W-1:0] lvl [0:`VIC_SRC_LAST];

  // Combinational views of the interrupt state
  logic [31:0] src_m;
  logic [31:0] f_hi;
  logic        fast_or;
  logic [31:0] f_sig;
  logic [31:0] f_sta;
  logic [31:0] n_sig;
  logic [31:0] n_sta;
  logic [`VIC_SRC_W-1:0] best_src;
  logic [`VIC_LVL_W-1:0] best_lvl;
  logic        best_hit;
  logic [31:0] vec_word;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic        setup;
  logic        acc_wr;

  // Level lookup per source; fields not wired read as level 7
  genvar g;
  generate
    for (g = 0; g <= `VIC_SRC_LAST; g++) begin : g_lvl
      // RL16: level per source
      if (g == 1) begin : g_sw
        // RL17: software field 6:4
        assign lvl[g] = s_q.pri0[6:4];
      end else if (g == 3) begin : g_t0
        // RL17: timer0 field 14:12
        assign lvl[g] = s_q.pri0[14:12];
      end else if (g == 4) begin : g_t1
        // RL17: timer1 field 18:16
        assign lvl[g] = s_q.pri0[18:16];
      end else if (g == 5) begin : g_t2
        // RL17: timer2 field 22:20
        assign lvl[g] = s_q.pri0[22:20];
      end else if (g == 6) begin : g_t3
        // RL17: timer3 field 26:24
        assign lvl[g] = s_q.pri0[26:24];
      end else if (g >= 10 && g <= 15) begin : g_p1
        assign lvl[g] = s_q.pri1[(g-10)*4+8 +: 3];
      end else if (g == 16) begin : g_p2a
        assign lvl[g] = s_q.pri2[2:0];
      end else if (g == 17) begin : g_p2b
        assign lvl[g] = s_q.pri2[6:4];
      end else if (g >= 18) begin : g_p2c
        assign lvl[g] = s_q.pri2[(g-18)*4+8 +: 3];
      end else begin : g_none
        // RL18: no field for source 0
        assign lvl[g] = `VIC_LVL_LOWEST;
      end
    end
  endgenerate

  // Status and signal words of both paths
  always_comb begin
    src_m = src_lines & `VIC_SRC_MASK;
    // RL21: fast enable gates the path
    f_hi = src_m & s_q.f_en;
    // RL6: programmed fast bypasses mask
    f_hi[`VIC_SRC_SW] = f_hi[`VIC_SRC_SW] | s_q.sw_f;
    // RL20: OR of fast bits 31:1
    fast_or = |f_hi[31:1];
    // RL2: status is signal AND enable
    f_sta = f_hi;
    f_sta[0] = fast_or;
    f_sig = src_m;
    f_sig[`VIC_SRC_SW] = src_m[`VIC_SRC_SW] | s_q.sw_f;
    f_sig[0] = fast_or;
    // RL7: programmed normal bypasses mask
    n_sig = src_m;
    n_sig[`VIC_SRC_SW] = src_m[`VIC_SRC_SW] | s_q.sw_n;
    n_sig[0] = fast_or;
    n_sta = src_m & s_q.n_en;
    n_sta[`VIC_SRC_SW] = n_sta[`VIC_SRC_SW] | s_q.sw_n;
    n_sta[0] = fast_or;
  end

  // Highest-priority active normal source
  always_comb begin
    best_src = '0;
    best_lvl = `VIC_LVL_LOWEST;
    best_hit = 1'b0;
    // RL22: strict compare keeps lowest index
    for (int i = 1; i <= `VIC_SRC_LAST; i++) begin
      if (n_sta[i] && (!best_hit || lvl[i] < best_lvl)) begin
        best_hit = 1'b1;
        best_lvl = lvl[i];
        best_src = `VIC_SRC_W'(i);
      end
    end
  end

  // Vector word; zero source field outside vectored mode
  always_comb begin
    vec_word = `VIC_RST_32;
    // RL14: base at 22:7, source at 6:2
    vec_word[`VIC_VEC_BASE_LO +: 16] = s_q.base;
    // RL4: no encoding unless vectored
    // RL9: control bit 0 enables it
    if (s_q.nest[`VIC_NEST_NORM]) begin
      vec_word[`VIC_VEC_SRC_LO +: `VIC_SRC_W] = best_src;
    end
  end

  // Read multiplexer; write-only registers read as zero
  always_comb begin
    rd_mux = `VIC_RST_32;
    rd_hit = 1'b1;
    unique case (paddr)
      `VIC_A_N_STA: rd_mux = n_sta;
      `VIC_A_N_SIG: rd_mux = n_sig;
      `VIC_A_N_EN:  rd_mux = s_q.n_en;
      `VIC_A_N_CLR: rd_mux = `VIC_RST_32;
      `VIC_A_SWCFG: rd_mux = `VIC_RST_32;
      // RL13: upper base bits read zero
      `VIC_A_BASE:  rd_mux = {16'h0000, s_q.base};
      // RL12: vector points into table
      `VIC_A_VEC:   rd_mux = vec_word;
      `VIC_A_PRI0:  rd_mux = s_q.pri0;
      `VIC_A_PRI1:  rd_mux = s_q.pri1;
      `VIC_A_PRI2:  rd_mux = s_q.pri2;
      `VIC_A_NEST:  rd_mux = {30'h0000_0000, s_q.nest};
      `VIC_A_F_STA: rd_mux = f_sta;
      `VIC_A_F_SIG: rd_mux = f_sig;
      `VIC_A_F_EN:  rd_mux = s_q.f_en;
      `VIC_A_F_CLR: rd_mux = `VIC_RST_32;
      default:      rd_hit = 1'b0;
    endcase
  end

  // Setup phase prepares the answer; access phase commits writes
  assign setup  = psel && !penable;
  assign acc_wr = psel && penable && pwrite && s_q.ready;

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    // Zero-wait answer: ready rises in the first access cycle
    s_d.ready = setup;
    s_d.err   = setup && !rd_hit;
    if (setup && !pwrite) begin
      s_d.rdata = rd_mux;
    end
    if (acc_wr && !s_q.err) begin
      unique case (paddr)
        `VIC_A_N_EN: begin
          // RL19: normal enable clears fast
          s_d.n_en = s_q.n_en | (pwdata & `VIC_SRC_MASK);
          s_d.f_en = s_q.f_en & ~(pwdata & `VIC_SRC_MASK);
        end
        `VIC_A_N_CLR: begin
          s_d.n_en = s_q.n_en & ~pwdata;
        end
        `VIC_A_SWCFG: begin
          // RL5: programmed sources both paths
          s_d.sw_n = pwdata[`VIC_SW_NORM];
          s_d.sw_f = pwdata[`VIC_SW_FAST];
        end
        `VIC_A_BASE: begin
          s_d.base = pwdata[15:0];
        end
        `VIC_A_PRI0: begin
          // RL18: low nibble stays reserved
          s_d.pri0 = pwdata & 32'h0777_7070;
        end
        `VIC_A_PRI1: begin
          s_d.pri1 = pwdata & 32'h7777_7700;
        end
        `VIC_A_PRI2: begin
          s_d.pri2 = pwdata & 32'h0000_7777;
        end
        `VIC_A_NEST: begin
          // RL10: control bit 1 for fast
          s_d.nest = pwdata[1:0];
        end
        `VIC_A_F_EN: begin
          // RL19: fast enable clears normal
          s_d.f_en = s_q.f_en | (pwdata & `VIC_SRC_MASK);
          s_d.n_en = s_q.n_en & ~(pwdata & `VIC_SRC_MASK);
        end
        `VIC_A_F_CLR: begin
          // RL1: ones clear fast enables
          s_d.f_en = s_q.f_en & ~pwdata;
        end
        default: begin
          s_d.err = s_q.err;
        end
      endcase
    end
    // RL3: any fast status bit requests
    s_d.fiq = fast_or;
    // RL11: both lines out; core ranks fast above normal
    s_d.irq = |n_sta;
  end

  // State register; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.n_en  <= `VIC_RST_32;
      s_q.f_en  <= `VIC_RST_32;
      s_q.sw_n  <= 1'b0;
      s_q.sw_f  <= 1'b0;
      s_q.base  <= `VIC_RST_16;
      s_q.pri0  <= `VIC_RST_32;
      s_q.pri1  <= `VIC_RST_32;
      s_q.pri2  <= `VIC_RST_32;
      s_q.nest  <= `VIC_RST_CTL;
      s_q.rdata <= `VIC_RST_32;
      s_q.ready <= 1'b0;
      s_q.err   <= 1'b0;
      s_q.irq   <= 1'b0;
      s_q.fiq   <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.err;
  assign irq_req = s_q.irq;
  assign fiq_req = s_q.fiq;

endmodule

/* verification/test_vectored_interrupt_controller.sv */
// Bench: APB register tests and held sources.
// Assumes vic_top, the source model and checker.
`timescale 1ns/1ns
`include "vic_defines.svh"
module test_vectored_interrupt_controller;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = ZERO;
  logic [31:0] pwdata = ZERO;
  logic [31:0] want = ZERO;
  logic [31:0] prdata, src_lines, rdq;
  logic        pready, pslverr, irq_req, fiq_req, erq;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          k;
  vic_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_lines(src_lines), .irq_req(irq_req), .fiq_req(fiq_req));
  vic_src_model u_src (.pclk(pclk), .want(want), .src_lines(src_lines));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic final_report();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // One APB transfer; held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) begin
      $display("[FAIL] %0t pready %h exp %h", $time, pready, 1'b1);
      miscompares++;
    end
    rdq = prdata;
    erq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, ZERO);
    chk(rdq, exp);
  endtask
  task automatic rq(input logic [1:0] e);
    chk({30'h0000_0000, irq_req, fiq_req}, {30'h0000_0000, e});
  endtask
  // Hang guard, far beyond the tests
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`VIC_A_F_EN, ZERO);
    rd(`VIC_A_VEC, ZERO);
    rd(`VIC_A_SWCFG, ZERO);
    rd(32'hFFFF_0018, ZERO);
    chk({31'h0000_0000, erq}, 32'h0000_0001);
    wr(`VIC_A_BASE, 32'hFFFF_A5C3);
    rd(`VIC_A_BASE, 32'h0000_A5C3);
    wr(`VIC_A_PRI0, 32'hFFFF_FFFF);
    rd(`VIC_A_PRI0, 32'h0777_7070);
    // Fast path from held sources
    want <= 32'h0000_1008;
    wr(`VIC_A_F_EN, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    rd(`VIC_A_F_STA, 32'h0000_0009);
    rq(2'h3);
    // Enabling one mask drops the bit in the other
    wr(`VIC_A_N_EN, 32'h0000_1008);
    rd(`VIC_A_F_EN, ZERO);
    rd(`VIC_A_N_STA, 32'h0000_1008);
    rq(2'h2);
    wr(`VIC_A_F_EN, 32'h0000_1000);
    rd(`VIC_A_N_EN, 32'h0000_0008);
    wr(`VIC_A_F_CLR, 32'hFFFF_EFFF);
    rd(`VIC_A_F_EN, 32'h0000_1000);
    wr(`VIC_A_F_CLR, 32'h0000_1000);
    rd(`VIC_A_F_EN, ZERO);
    // Vector field stays zero until nesting is on
    wr(`VIC_A_N_EN, 32'h0000_1000);
    rd(`VIC_A_VEC, 32'h0052_E180);
    wr(`VIC_A_NEST, 32'h0000_0003);
    rd(`VIC_A_NEST, 32'h0000_0003);
    rd(`VIC_A_VEC, 32'h0052_E1B0);
    wr(`VIC_A_PRI1, 32'h0007_0000);
    rd(`VIC_A_VEC, 32'h0052_E18C);
    // Programmed interrupts with all masks cleared
    want <= ZERO;
    wr(`VIC_A_N_CLR, 32'hFFFF_FFFF);
    for (k = 0; k < 4; k++) begin
      wr(`VIC_A_SWCFG, {29'h0000_0000, k[1:0], 1'b0});
      repeat (2) @(posedge pclk);
      rd(`VIC_A_F_STA, {30'h0000_0000, k[1], k[1]});
      rd(`VIC_A_N_STA, {30'h0000_0000, k[0], k[1]});
      rq({k[0] | k[1], k[1]});
    end
    final_report();
  end
endmodule

/* verification/vic_src_model.sv */
// Peripheral source lines toward the controller.
// Assumes the bench sets wanted levels after an edge.
`timescale 1ns/1ns
module vic_src_model (
  // Clock and wanted levels
  input  wire logic        pclk,
  input  wire logic [31:0] want,
  // Lines into the controller
  output logic      [31:0] src_lines = 32'h0000_0000
);
  logic age_q = 1'b0;
  // hold each level
  // One idle edge after a change, so a level always stands two cycles
  always @(posedge pclk) begin
    if (age_q) age_q <= 1'b0;
    else if (want != src_lines) begin
      src_lines <= want;
      age_q <= 1'b1;
    end
  end
endmodule

/* verification/vic_top_sva.sv */
// Checker on the controller ports.
// Assumes zero-wait APB and the vic_top port list.
`timescale 1ns/1ns
`include "vic_defines.svh"
module vic_top_sva (
  // Clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Sources and requests
  input wire logic [31:0] src_lines,
  input wire logic        irq_req,
  input wire logic        fiq_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted write and read in the access phase
  sequence s_wr(a); psel && penable && pready && pwrite && paddr == a; endsequence
  sequence s_rd(a); psel && penable && pready && !pwrite && paddr == a; endsequence
  property p_rdy; psel && !penable && ce |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pslverr && !pwrite |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_vec; s_rd(`VIC_A_VEC) |-> prdata[31:23] == 9'h000 && prdata[1:0] == 2'h0; endproperty
  a_vec: assert property (p_vec) else $error("vector pad bits set");
  property p_fsta; s_rd(`VIC_A_F_STA) |-> prdata[0] == (|prdata[31:1]); endproperty
  a_fsta: assert property (p_fsta) else $error("fast bit0 not OR");
  property p_fiq; fiq_req |-> irq_req; endproperty
  a_fiq: assert property (p_fiq) else $error("normal bit0 missing");
  property p_swn; s_wr(`VIC_A_SWCFG) ##0 pwdata[1] |-> ##[1:3] irq_req; endproperty
  a_swn: assert property (p_swn) else $error("soft normal lost");
  property p_swf; s_wr(`VIC_A_SWCFG) ##0 pwdata[2] |-> ##[1:3] fiq_req; endproperty
  a_swf: assert property (p_swf) else $error("soft fast lost");
endmodule

bind vic_top vic_top_sva u_sva (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_lines(src_lines), .irq_req(irq_req), .fiq_req(fiq_req));
